// *** hdl/ftc_pkg.sv ***
// Constants of the fan tachometer counter: offsets, fields, reset values.
// Assumes an APB master with 32-bit data and one clock, pclk.
`default_nettype none

package ftc_pkg;
   // ***************************************
   // Register map
   // ***************************************
   localparam logic [7:0] FTC_SPEED_OFF   = 8'h00;
   localparam logic [7:0] FTC_PRELOAD_OFF = 8'h04;
   localparam logic [7:0] FTC_CONFIG_OFF  = 8'h08;

   // ***************************************
   // Fields and reset values
   // ***************************************
   localparam int         FTC_DIV_LSB       = 4;
   localparam int         FTC_DIV_MSB       = 5;
   localparam logic [7:0] FTC_SPEED_RST     = 8'h00;
   localparam logic [7:0] FTC_PRELOAD_RST   = 8'h00;
   localparam logic [1:0] FTC_DIV_RST       = 2'h2;
   localparam int         FTC_CNT_W         = 8;
   localparam int         FTC_PRESCALE_W    = 3;
endpackage : ftc_pkg

`default_nettype wire

// *** hdl/ftc_tick_if.sv ***
// Interface between the register core and the count clock prescaler.
// Assumes both ends run on pclk.
`default_nettype none

interface ftc_tick_if;
   logic [1:0] div_sel;
   logic       tick;
   modport src  (input div_sel, output tick);
   modport user (output div_sel, input tick);
endinterface : ftc_tick_if

`default_nettype wire

// *** hdl/ftc_prescaler.sv ***
// Count clock prescaler: one-cycle tick every 1, 2, 4 or 8 clocks.
// Assumes pclk and an active-low asynchronous reset.
`default_nettype none

module ftc_prescaler (
   input  wire logic    pclk,
   input  wire logic    presetn,
   ftc_tick_if.src      tk
);
   logic [ftc_pkg::FTC_PRESCALE_W-1:0] cnt_ff;
   logic [ftc_pkg::FTC_PRESCALE_W-1:0] mask;
   logic                               tick_ff;

   // ***************************************
   // Divider
   // ***************************************
   // Mask of low bits that must all be one: 0, 1, 3 or 7
   always_comb begin
      case (tk.div_sel)
         2'h0:    mask = 3'h0;
         2'h1:    mask = 3'h1;
         2'h2:    mask = 3'h3;
         default: mask = 3'h7;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 3'h0;
      end else begin
         cnt_ff <= cnt_ff + 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= ((cnt_ff & mask) == mask);
      end
   end

   assign tk.tick = tick_ff;
endmodule : ftc_prescaler

`default_nettype wire

// *** hdl/ftc_fan_tach.sv ***
// Fan tachometer counter with an APB register slave.
// Assumes tach_in is already synchronous to pclk; one pulse is rising edge to rising edge.
`default_nettype none

module ftc_fan_tach #(
   parameter int CNT_W = ftc_pkg::FTC_CNT_W
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        tach_in
);
   // ***************************************
   // State
   // ***************************************
   ftc_tick_if tk ();

   logic [CNT_W-1:0] speed_ff;
   logic [CNT_W-1:0] nxt_speed;
   logic [CNT_W-1:0] preload_ff;
   logic [CNT_W-1:0] nxt_preload;
   logic [1:0]       div_ff;
   logic [1:0]       nxt_div;
   logic [CNT_W-1:0] run_ff;
   logic [CNT_W-1:0] nxt_run;
   logic             tach_prev_ff;
   logic             pulse_end;
   logic             run_full;
   logic             count_en;
   logic             setup_ph;
   logic             access_ph;
   logic             wr_en;
   logic             rd_en;
   logic             hit_speed;
   logic             hit_preload;
   logic             hit_config;
   logic             mapped;
   logic [31:0]      rd_word;
   logic [31:0]      prdata_ff;
   logic [31:0]      nxt_prdata;
   logic             pready_ff;
   logic             nxt_pready;
   logic             pslverr_ff;
   logic             nxt_pslverr;

   // ***************************************
   // Count clock prescaler
   // ***************************************
   ftc_prescaler u_prescaler (
      .pclk    (pclk),
      .presetn (presetn),
      .tk      (tk)
   );

   assign tk.div_sel = div_ff;

   // ***************************************
   // Tachometer edge detect
   // ***************************************
   // Pulse boundary is the rising edge; tach_in is taken as already synchronous
   assign pulse_end = tach_in & ~tach_prev_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tach_prev_ff <= 1'b0;
      end else begin
         tach_prev_ff <= tach_in;
      end
   end

   // ***************************************
   // Running count
   // ***************************************
   assign run_full = (run_ff == {CNT_W{1'b1}});
   assign count_en = tk.tick & ~run_full;

   // Saturates so that a slow fan reads full scale at its next edge, never wraps to a fast reading
   always_comb begin
      nxt_run = run_ff;
      if (pulse_end) begin
         nxt_run = preload_ff;
      end else if (count_en) begin
         nxt_run = run_ff + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ff <= ftc_pkg::FTC_PRELOAD_RST;
      end else begin
         run_ff <= nxt_run;
      end
   end

   // ***************************************
   // Speed latch
   // ***************************************
   // A preload write mid-pulse spoils this pulse only, since the next reloads the new preload; software skips it
   always_comb begin
      nxt_speed = speed_ff;
      if (pulse_end) begin
         nxt_speed = run_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_ff <= ftc_pkg::FTC_SPEED_RST;
      end else begin
         speed_ff <= nxt_speed;
      end
   end

   // ***************************************
   // APB decode
   // ***************************************
   assign setup_ph    = psel & ~penable;
   assign access_ph   = psel & penable;
   assign wr_en       = access_ph & pwrite & pready_ff;
   assign rd_en       = setup_ph & ~pwrite;
   assign hit_speed   = (paddr == ftc_pkg::FTC_SPEED_OFF);
   assign hit_preload = (paddr == ftc_pkg::FTC_PRELOAD_OFF);
   assign hit_config  = (paddr == ftc_pkg::FTC_CONFIG_OFF);
   assign mapped      = hit_speed | hit_preload | hit_config;

   // ***************************************
   // Preload register
   // ***************************************
   always_comb begin
      nxt_preload = preload_ff;
      if (wr_en && hit_preload) begin
         nxt_preload = pwdata[CNT_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         preload_ff <= ftc_pkg::FTC_PRELOAD_RST;
      end else begin
         preload_ff <= nxt_preload;
      end
   end

   // ***************************************
   // Divisor field
   // ***************************************
   // Only the divisor bits are stored; the rest of the word reads back zero
   always_comb begin
      nxt_div = div_ff;
      if (wr_en && hit_config) begin
         nxt_div = pwdata[ftc_pkg::FTC_DIV_MSB:ftc_pkg::FTC_DIV_LSB];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= ftc_pkg::FTC_DIV_RST;
      end else begin
         div_ff <= nxt_div;
      end
   end

   // ***************************************
   // Read data select
   // ***************************************
   always_comb begin
      rd_word = 32'h0;
      case (paddr)
         ftc_pkg::FTC_SPEED_OFF:   rd_word[CNT_W-1:0] = speed_ff;
         ftc_pkg::FTC_PRELOAD_OFF: rd_word[CNT_W-1:0] = preload_ff;
         ftc_pkg::FTC_CONFIG_OFF:  rd_word[ftc_pkg::FTC_DIV_MSB:ftc_pkg::FTC_DIV_LSB] = div_ff;
         default:                  rd_word = 32'h0;
      endcase
   end

   // ***************************************
   // APB response
   // ***************************************
   // Answer is ready in the first access cycle: zero wait states
   always_comb begin
      nxt_pready  = setup_ph;
      nxt_pslverr = setup_ph & ~mapped;
      nxt_prdata  = 32'h0;
      if (rd_en) begin
         nxt_prdata = rd_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= nxt_pready;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= nxt_pslverr;
      end
   end

   // Read data falls to zero outside the access cycle so stale values never linger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end

   // ***************************************
   // Outputs
   // ***************************************
   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
endmodule : ftc_fan_tach

`default_nettype wire

// *** bench/ftc_fan_model.sv ***
// Fan model: tach square wave, period 2*half_per clocks.
// Assumes the output may be synchronous to pclk.
`default_nettype none
module ftc_fan_model (
   input  wire logic       pclk,
   input  wire logic [7:0] half_per,
   output logic            tach_in
);
   timeunit 1ns;
   timeprecision 1ps;
   int   n        = 0;
   logic tach_lvl = 1'b0;
   // Free-running, like a spinning fan
   always @(posedge pclk) begin
      n++;
      if (n >= half_per) begin
         n = 0;
         tach_lvl <= ~tach_lvl;
      end
   end
   assign tach_in = tach_lvl;
endmodule : ftc_fan_model
`default_nettype wire

// *** bench/ftc_fan_tach_asserts.sv ***
// Port checker of the fan tachometer counter.
// Sees only the top module's ports.
`default_nettype none
module ftc_fan_tach_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        tach_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pre_ff;
   wire logic  rd = pready && !pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pre_ff <= 8'h00;
      else if (pready && pwrite && paddr == 8'h04) pre_ff <= pwdata[7:0];
   end
   chk_setup_ans: assert property (psel && !penable |=> pready) else $error("no ready");
   chk_ready_one: assert property (pready |=> !pready) else $error("ready held");
   chk_idle_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("idle bus");
   chk_read_width: assert property (rd |-> prdata[31:8] == 24'h0) else $error("wide read");
   chk_cfg_field: assert property (rd && paddr == 8'h08 |-> prdata[7:6] == 2'h0 && prdata[3:0] == 4'h0)
      else $error("config bits");
   chk_bad_err: assert property (pready && paddr > 8'h08 |-> pslverr) else $error("no error");
   chk_good_ok: assert property (pready && paddr <= 8'h08 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error");
   chk_preload_echo: assert property (rd && paddr == 8'h04 |-> prdata[7:0] == pre_ff)
      else $error("preload");
endmodule : ftc_fan_tach_asserts
bind ftc_fan_tach ftc_fan_tach_asserts chk_u (.*);
`default_nettype wire

// *** bench/tb.sv ***
// Bench of the fan tachometer counter.
// Assumes zero-wait APB and a tach synchronous to pclk.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, tach_in, pready, pslverr;
   logic [7:0]  paddr, half_per;
   logic [31:0] pwdata, prdata, r;
   int          err_total, samples_checked, p, e, t, mdl_pre, mdl_div;
   ftc_fan_tach dut_u (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .tach_in (tach_in)
   );
   ftc_fan_model fan_u (
      .pclk     (pclk),
      .half_per (half_per),
      .tach_in  (tach_in)
   );
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   task close_out;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (t = 0; t < 20 && pready !== 1'b1; t++) @(posedge pclk);
      r = prdata;
      psel <= 0;
      penable <= 0;
      if (t == 20) begin
         err_total++;
         $display("[FAIL] pready exp 1 got 0");
      end
   endtask : apb
   task chk(input int ex, input int tol);
      samples_checked++;
      if ($isunknown(r) || r > ex + tol || r + tol < ex) begin
         err_total++;
         $display("[FAIL] reg %h exp %0d got %0d", paddr, ex, r);
      end
   endtask : chk
   task rst_chk(input int n);
      presetn <= 0;
      repeat (n) @(posedge pclk);
      presetn <= 1;
      mdl_pre = 0;
      mdl_div = 2;
      for (int k = 0; k < 4; k++) begin
         apb(0, 8'(k * 4), 0);
         chk(k == 2 ? mdl_div << 4 : 0, 0);
      end
      $display("test reset done");
   endtask : rst_chk
   initial begin
      #100000;
      err_total++;
      $display("[FAIL] watchdog exp done got timeout");
      close_out;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      half_per = 8'h14;
      void'($urandom(60));
      rst_chk(3);
      for (int d = 0; d < 5; d++) begin
         p = (d == 4) ? 240 : $urandom % 64;
         mdl_div = d % 4;
         mdl_pre = p;
         apb(1, 8'h08, 32'(mdl_div) << 4);
         apb(1, 8'h04, p);
         apb(0, 8'h08, 0);
         chk(mdl_div << 4, 0);
         apb(0, 8'h04, 0);
         chk(mdl_pre, 0);
         repeat (3) @(posedge tach_in);
         repeat ($urandom % 30) @(posedge pclk);
         apb(0, 8'h00, 0);
         e = mdl_pre + 2 * half_per / (1 << mdl_div);
         chk(e > 255 ? 255 : e, 1);
         $display("test %0d done", d);
      end
      // Reset early in a tach pulse so no real edge lands before the reads
      @(posedge tach_in);
      rst_chk(3);
      close_out;
   end
endmodule : tb
`default_nettype wire
